// ===== core/di_pkg.sv
// shared constants and types of the status input conditioning block
package cond_pkg;
   localparam int          NUM_INPUTS    = 64;
   localparam int          SMALL_INPUTS  = 16;
   localparam int          CLK_HZ        = 10_000_000;
   localparam int          WINDOW_MS     = 1000;
   localparam int          WINDOW_CYCLES = CLK_HZ / 1000 * WINDOW_MS;
   localparam int          DB_W          = 16;
   localparam int          CH_W          = 8;
   localparam int          DB_LSB        = 0;
   localparam int          ON_LSB        = 16;
   localparam int          OFF_LSB       = 24;
   localparam logic [15:0] DB_RST        = 16'h03e8;
   localparam logic [7:0]  ON_RST        = 8'h0a;
   localparam logic [7:0]  OFF_RST       = 8'h05;
   localparam logic [31:0] CFG_RST       = {OFF_RST, ON_RST, DB_RST};
   localparam logic [11:0] DP_OFF        = 12'h000;
   localparam logic [11:0] TAG_LO_OFF    = 12'h004;
   localparam logic [11:0] TAG_HI_OFF    = 12'h008;
   localparam logic [11:0] STATE_LO_OFF  = 12'h00c;
   localparam logic [11:0] STATE_HI_OFF  = 12'h010;
   localparam logic [11:0] QUAL_LO_OFF   = 12'h014;
   localparam logic [11:0] QUAL_HI_OFF   = 12'h018;
   localparam logic [11:0] TIME_OFF      = 12'h01c;
   localparam logic [3:0]  CFG_PAGE      = 4'h1;

   typedef enum logic [1:0] {
      PT_OFF     = 2'b00,
      PT_ON      = 2'b01,
      PT_TRANS   = 2'b10,
      PT_INVALID = 2'b11
   } point_state_t;

   typedef enum logic [1:0] {
      EV_CHANGE  = 2'b00,
      EV_BLOCK   = 2'b01,
      EV_UNBLOCK = 2'b11
   } event_kind_t;

   typedef struct packed {
      event_kind_t  kind;
      logic [5:0]   index;
      point_state_t state;
      logic         invalid;
      logic         time_tagged_report;
      logic [31:0]  stamp;
   } event_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_t;

   function automatic point_state_t decode_point(input logic dp,
      input logic msb, input logic lsb);
      point_state_t r;
      r = PT_INVALID;
      if (!dp)
         r = lsb ? PT_ON : PT_OFF;
      else
         case ({msb, lsb})
            2'b01:   r = PT_OFF;
            2'b00:   r = PT_TRANS;
            2'b10:   r = PT_ON;
            default: r = PT_INVALID;
         endcase
      return r;
   endfunction
endpackage

// ===== core/debounce_unit.sv
// debounce filter for one status input
`timescale 1ns/1ps
module debounce_unit
   import cond_pkg::*;
#(
   parameter int CNT_W = DB_W
)(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             din,
   input  wire logic [CNT_W-1:0] period,
   output logic                  dout,
   output logic                  chg
);
   typedef struct packed {
      logic             cand;
      logic [CNT_W-1:0] cnt;
      logic             out;
      logic             chg;
   } db_state_t;

   db_state_t q;
   db_state_t d;

   always_comb
   begin
      d     = q;
      d.chg = 1'b0;
      if (din != q.cand)
      begin
         // any movement restarts the stable time
         d.cand = din;
         d.cnt  = '0;
      end
      else if (q.cand != q.out)
      begin
         if (q.cnt >= period)
         begin
            d.out = q.cand;
            d.chg = 1'b1;
         end
         else
            d.cnt = q.cnt + 1'b1;
      end
      else
         d.cnt = '0;
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         q <= '0;
      else
         q <= d;

   assign dout = q.out;
   assign chg  = q.chg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   db_stable_a: assert property (
      q.chg |-> $past(q.cnt) >= $past(period) && $past(din) == q.out)
      else $error("debounce accepted a level before its period");
   db_hold_a: assert property (
      q.out != $past(q.out) |-> q.chg)
      else $error("debounce output moved without a change pulse");
endmodule

// ===== core/chatter_unit.sv
// oscillation (chatter) filter for one debounced status input
`timescale 1ns/1ps
module chatter_unit
   import cond_pkg::*;
#(
   parameter int CW = CH_W
)(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          din,
   input  wire logic          chg_in,
   input  wire logic          win_tick,
   input  wire logic [CW-1:0] on_lvl,
   input  wire logic [CW-1:0] off_lvl,
   output logic               state_o,
   output logic               chg_o,
   output logic               blocked,
   output logic               qev
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          blocked;
      logic          state;
      logic          chg;
      logic          qev;
   } ch_state_t;

   ch_state_t q;
   ch_state_t d;

   always_comb
   begin
      logic [CW-1:0] base;
      base  = win_tick ? '0 : q.cnt;
      d     = q;
      d.chg = 1'b0;
      d.qev = 1'b0;
      // saturate so a wild input cannot wrap back under the trigger
      if (chg_in && base != '1)
         d.cnt = base + 1'b1;
      else
         d.cnt = base;
      if (!q.blocked)
      begin
         if (chg_in && base >= on_lvl)
         begin
            d.blocked = 1'b1;
            d.qev     = 1'b1;
         end
         else if (chg_in)
         begin
            d.state = din;
            d.chg   = 1'b1;
         end
      end
      else if (win_tick && q.cnt < off_lvl)
      begin
         d.blocked = 1'b0;
         d.qev     = 1'b1;
         if (din != q.state)
         begin
            d.state = din;
            d.chg   = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         q <= '0;
      else
         q <= d;

   assign state_o = q.state;
   assign chg_o   = q.chg;
   assign blocked = q.blocked;
   assign qev     = q.qev;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ch_block_a: assert property (
      !q.blocked && chg_in && !win_tick && q.cnt >= on_lvl
      |=> q.blocked && q.qev)
      else $error("chatter filter failed to block");
   ch_freeze_a: assert property (
      q.blocked && $past(q.blocked) |-> $stable(q.state) && !q.chg)
      else $error("blocked input changed its reported state");
   ch_unblock_a: assert property (
      q.blocked && win_tick && q.cnt < off_lvl |=> !q.blocked && q.qev)
      else $error("chatter filter failed to release");
   ch_stay_a: assert property (
      q.blocked && !(win_tick && q.cnt < off_lvl) |=> q.blocked)
      else $error("chatter filter released early");
endmodule

// ===== core/status_input_top.sv
// status input conditioning: sync, debounce, chatter, events, apb
`timescale 1ns/1ps
module status_input_top
   import cond_pkg::*;
#(
   parameter int N_INPUTS   = NUM_INPUTS,
   parameter int WIN_CYCLES = WINDOW_CYCLES
)(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire apb_req_t            apb_i,
   output apb_rsp_t                 apb_o,
   input  wire logic [N_INPUTS-1:0] status_input,
   input  wire logic                evt_ready,
   output logic                     evt_valid,
   output event_t                   evt_o,
   output logic [N_INPUTS-1:0]      qual_o
);
   typedef struct packed {
      logic [NUM_INPUTS-1:0]             s1;
      logic [NUM_INPUTS-1:0]             s2;
      logic [NUM_INPUTS-1:0][31:0]       cfg;
      logic [NUM_INPUTS/2-1:0]           dp;
      logic [NUM_INPUTS-1:0]             tag;
      logic [31:0]                       now;
      logic [31:0]                       win;
      logic [NUM_INPUTS-1:0]             cpend;
      logic [NUM_INPUTS-1:0]             qpend;
      logic [NUM_INPUTS-1:0][31:0]       stamp;
      logic                              evalid;
      event_t                            ev;
      logic [31:0]                       rdata;
      logic                              slverr;
   } top_state_t;

   top_state_t                   q;
   top_state_t                   d;
   logic [NUM_INPUTS-1:0]        db_out;
   logic [NUM_INPUTS-1:0]        db_chg;
   logic [NUM_INPUTS-1:0]        st_c;
   logic [NUM_INPUTS-1:0]        chg_c;
   logic [NUM_INPUTS-1:0]        blk_c;
   logic [NUM_INPUTS-1:0]        qev_c;
   logic [NUM_INPUTS-1:0]        pqual;
   point_state_t [NUM_INPUTS-1:0] pstate;
   logic                         win_tick;
   logic                         setup;
   logic                         access;

   function automatic logic reg_mapped(input logic [11:0] a);
      return a[1:0] == 2'b00 && (a <= TIME_OFF || a[11:8] == CFG_PAGE);
   endfunction

   assign win_tick = q.win == 32'(WIN_CYCLES - 1);
   assign setup    = apb_i.psel && !apb_i.penable;
   assign access   = apb_i.psel && apb_i.penable;

   for (genvar g = 0; g < NUM_INPUTS; g++)
   begin : g_in
      debounce_unit #(.CNT_W(DB_W)) u_db (
         .pclk    (pclk),
         .presetn (presetn),
         .din     (q.s2[g]),
         .period  (q.cfg[g][DB_LSB +: DB_W]),
         .dout    (db_out[g]),
         .chg     (db_chg[g])
      );
      chatter_unit #(.CW(CH_W)) u_ch (
         .pclk     (pclk),
         .presetn  (presetn),
         .din      (db_out[g]),
         .chg_in   (db_chg[g]),
         .win_tick (win_tick),
         .on_lvl   (q.cfg[g][ON_LSB +: CH_W]),
         .off_lvl  (q.cfg[g][OFF_LSB +: CH_W]),
         .state_o  (st_c[g]),
         .chg_o    (chg_c[g]),
         .blocked  (blk_c[g]),
         .qev      (qev_c[g])
      );
      if (g % 2 == 0)
      begin : g_lo
         assign pstate[g] = decode_point(q.dp[g/2], st_c[g+1], st_c[g]);
         assign pqual[g]  = blk_c[g] | (q.dp[g/2] & blk_c[g+1]);
      end
      else
      begin : g_hi
         // the high half of a double point has no point of its own
         assign pstate[g] = decode_point(1'b0, 1'b0, st_c[g]);
         assign pqual[g]  = blk_c[g] & ~q.dp[g/2];
      end
   end

   always_comb
   begin
      int          p;
      logic [5:0]  sel;
      logic        hit;
      logic [11:0] a;
      logic [31:0] rd;
      p        = 0;
      sel      = '0;
      hit      = 1'b0;
      a        = apb_i.paddr;
      rd       = '0;
      d        = q;
      d.s1     = NUM_INPUTS'(status_input);
      d.s2     = q.s1;
      d.now    = q.now + 32'd1;
      d.win    = win_tick ? '0 : q.win + 32'd1;
      d.slverr = 1'b0;

      if (a == DP_OFF)
         rd = q.dp;
      else if (a == TAG_LO_OFF)
         rd = q.tag[31:0];
      else if (a == TAG_HI_OFF)
         rd = q.tag[63:32];
      else if (a == STATE_LO_OFF)
         rd = st_c[31:0];
      else if (a == STATE_HI_OFF)
         rd = st_c[63:32];
      else if (a == QUAL_LO_OFF)
         rd = pqual[31:0];
      else if (a == QUAL_HI_OFF)
         rd = pqual[63:32];
      else if (a == TIME_OFF)
         rd = q.now;
      else if (a[11:8] == CFG_PAGE)
         rd = q.cfg[a[7:2]];
      if (setup)
      begin
         // read data is latched in setup so the access cycle can finish
         d.rdata  = reg_mapped(a) ? rd : '0;
         d.slverr = !reg_mapped(a);
      end

      if (access && apb_i.pwrite && reg_mapped(a))
      begin
         if (a == DP_OFF)
            d.dp = apb_i.pwdata;
         else if (a == TAG_LO_OFF)
            d.tag[31:0] = apb_i.pwdata;
         else if (a == TAG_HI_OFF)
            d.tag[63:32] = apb_i.pwdata;
         else if (a == TIME_OFF)
            d.now = apb_i.pwdata;
         else if (a[11:8] == CFG_PAGE)
            d.cfg[a[7:2]] = apb_i.pwdata;
      end

      if (!q.evalid || evt_ready)
      begin
         d.evalid = 1'b0;
         for (int i = NUM_INPUTS - 1; i >= 0; i--)
            if (q.qpend[i] || q.cpend[i])
            begin
               hit = 1'b1;
               sel = 6'(i);
            end
         if (hit)
         begin
            d.evalid                = 1'b1;
            d.ev.index              = sel;
            d.ev.state              = pstate[sel];
            d.ev.invalid            = pqual[sel];
            d.ev.time_tagged_report = q.tag[sel];
            if (q.qpend[sel])
            begin
               d.ev.kind       = pqual[sel] ? EV_BLOCK : EV_UNBLOCK;
               d.ev.stamp      = q.now;
               d.qpend[sel]    = 1'b0;
            end
            else
            begin
               d.ev.kind       = EV_CHANGE;
               d.ev.stamp      = q.stamp[sel];
               d.cpend[sel]    = 1'b0;
            end
            if (!q.tag[sel])
               d.ev.stamp = '0;
         end
      end

      // sets come after the clears so a same-cycle event is kept
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
         p = (i % 2 == 1 && q.dp[i/2]) ? i - 1 : i;
         if (chg_c[i])
         begin
            d.cpend[p] = 1'b1;
            d.stamp[p] = q.now;
         end
         if (qev_c[i])
            d.qpend[p] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         q <= '0;
         for (int i = 0; i < NUM_INPUTS; i++)
            q.cfg[i] <= CFG_RST;
      end
      else
         q <= d;

   assign apb_o.pready  = 1'b1;
   assign apb_o.prdata  = q.rdata;
   assign apb_o.pslverr = q.slverr;
   assign evt_valid     = q.evalid;
   assign evt_o         = q.ev;
   assign qual_o        = pqual[N_INPUTS-1:0];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_error_a: assert property (
      setup && !reg_mapped(apb_i.paddr) |=> apb_o.pslverr)
      else $error("unmapped address not refused");
   single_decode_a: assert property (
      !q.dp[0] |-> pstate[0] == (st_c[0] ? PT_ON : PT_OFF))
      else $error("single point decoded wrongly");
   double_decode_a: assert property (
      q.dp[1] |-> pstate[2] == (st_c[3] ? (st_c[2] ? PT_INVALID : PT_ON)
                                        : (st_c[2] ? PT_OFF : PT_TRANS)))
      else $error("double point decoded wrongly");
   msb_quiet_a: assert property (
      q.evalid |-> !(q.ev.index[0] && q.dp[q.ev.index[5:1]]))
      else $error("event issued on high half of a double point");
   untagged_stamp_a: assert property (
      q.evalid && !q.ev.time_tagged_report |-> q.ev.stamp == '0)
      else $error("untagged event carries a time");
   evt_hold_a: assert property (
      q.evalid && !evt_ready |=> q.evalid && $stable(q.ev))
      else $error("event dropped before it was taken");

   // bus side: zero wait states, refused reads carry no data
   apb_zero_a: assert property (
      setup && !reg_mapped(apb_i.paddr) |=> apb_o.prdata == '0)
      else $error("refused read returned data");
   apb_ready_a: assert property (
      access |-> apb_o.pready)
      else $error("access cycle not answered at once");
   dp_write_a: assert property (
      access && apb_i.pwrite && apb_i.paddr == DP_OFF
      |=> q.dp == $past(apb_i.pwdata))
      else $error("double point enable write lost");
   tag_write_a: assert property (
      access && apb_i.pwrite && apb_i.paddr == TAG_LO_OFF
      |=> q.tag[31:0] == $past(apb_i.pwdata))
      else $error("low tag mode write lost");
   tag_hi_write_a: assert property (
      access && apb_i.pwrite && apb_i.paddr == TAG_HI_OFF
      |=> q.tag[63:32] == $past(apb_i.pwdata))
      else $error("high tag mode write lost");
   cfg_write_a: assert property (
      access && apb_i.pwrite && apb_i.paddr[11:8] == CFG_PAGE
      && apb_i.paddr[1:0] == 2'b00
      |=> q.cfg[$past(apb_i.paddr[7:2])] == $past(apb_i.pwdata))
      else $error("per input config write lost");
   state_read_a: assert property (
      setup && apb_i.paddr == STATE_LO_OFF
      |=> apb_o.prdata == $past(st_c[31:0]))
      else $error("filtered state read wrong");
   qual_read_a: assert property (
      setup && apb_i.paddr == QUAL_LO_OFF
      |=> apb_o.prdata == $past(pqual[31:0]))
      else $error("quality read wrong");

   // a filtered change or alarm must never be lost to a same-cycle clear
   chg_pend_a: assert property (
      chg_c[0] |=> q.cpend[0])
      else $error("filtered change not queued");
   alarm_pend_a: assert property (
      qev_c[4] |=> q.qpend[4])
      else $error("chatter alarm not queued");
   block_flag_a: assert property (
      q.evalid && q.ev.kind == EV_BLOCK |-> q.ev.invalid)
      else $error("block alarm without invalid status");
   release_flag_a: assert property (
      q.evalid && q.ev.kind == EV_UNBLOCK |-> !q.ev.invalid)
      else $error("release event still flagged invalid");
endmodule

// ===== tb/field_model.sv
// far side model: field contacts and the upstream event taker
`timescale 1ns/1ps
module field_model
   import cond_pkg::*;
(
   input  wire logic    pclk,
   input  wire logic    presetn,
   input  wire logic    slow,
   input  wire logic    evt_valid,
   input  wire event_t  evt_o,
   output logic         evt_ready,
   output logic [63:0]  status_input
);
   logic [63:0] pins = '0;
   event_t      got [$];

   assign status_input = pins;

   // a slow taker drops ready every other cycle so offers must hold
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         evt_ready <= 1'b0;
      else
      begin
         if (evt_valid && evt_ready)
            got.push_back(evt_o);
         evt_ready <= slow ? !evt_ready : 1'b1;
      end
endmodule

// ===== tb/digital_input_debounce_chatter_tb_top.sv
// self-checking bench of the status input conditioning block
`timescale 1ns/1ps
module digital_input_debounce_chatter_tb_top
   import cond_pkg::*;
;
   localparam int WIN = 200;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        slow = 1'b0;
   apb_req_t    req = '0;
   apb_rsp_t    rsp;
   logic        evt_ready;
   logic        evt_valid;
   event_t      evt;
   logic [63:0] pins_w;
   logic [63:0] qual;
   int          bad_count = 0;
   int          check_count = 0;
   int          cycles = 0;

   always #50 pclk = ~pclk;

   status_input_top #(.N_INPUTS(64), .WIN_CYCLES(WIN)) dut (
      .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
      .status_input(pins_w), .evt_ready(evt_ready),
      .evt_valid(evt_valid), .evt_o(evt), .qual_o(qual));

   field_model fm (.pclk(pclk), .presetn(presetn), .slow(slow),
      .evt_valid(evt_valid), .evt_o(evt), .evt_ready(evt_ready),
      .status_input(pins_w));

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         $display("[ERR] %0t run too long", $time);
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      req <= apb_req_t'{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1)
         @(posedge pclk);
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input logic eexp, input string what);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, what);
      chk(32'(e), 32'(eexp), what);
   endtask

   task automatic cfg(input int i, input logic [15:0] per,
                      input logic [7:0] on, input logic [7:0] off);
      wr(12'h100 + 12'(4 * i), {off, on, per});
   endtask

   task automatic pin(input int i, input logic v);
      @(posedge pclk);
      fm.pins[i] <= v;
   endtask

   task automatic chk_ev(input event_kind_t k, input int i,
                         input point_state_t s, input logic inv,
                         input logic tg, input string what);
      event_t e;
      repeat (400)
         if (fm.got.size() == 0)
            @(posedge pclk);
      if (fm.got.size() == 0)
         e = '1;
      else
         e = fm.got.pop_front();
      chk(32'({e.kind, e.index, e.state, e.invalid, e.time_tagged_report}),
          32'({k, 6'(i), s, inv, tg}), what);
      chk(32'(e.stamp !== 32'h0), 32'(tg), what);
   endtask

   task automatic t_reset();
      rd(12'h114, CFG_RST, 1'b0, "cfg reset");
      rd(12'h020, 32'h0, 1'b1, "unmapped");
      rd(QUAL_LO_OFF, 32'h0, 1'b0, "quality reg");
      chk(qual[31:0], 32'h0, "quality pins");
      $display("test reset done");
   endtask

   task automatic t_single();
      cfg(0, 16'h0004, 8'h03, 8'h01);
      cfg(1, 16'h0014, 8'h03, 8'h01);
      @(posedge pclk);
      fm.pins[1:0] <= 2'b11;
      chk_ev(EV_CHANGE, 0, PT_ON, 1'b0, 1'b0, "single on");
      chk(32'(fm.got.size()), 32'h0, "own period");
      chk_ev(EV_CHANGE, 1, PT_ON, 1'b0, 1'b0, "single on 1");
      pin(0, 1'b0);
      repeat (2) @(posedge pclk);
      pin(0, 1'b1);
      repeat (40) @(posedge pclk);
      chk(32'(fm.got.size()), 32'h0, "glitch dropped");
      pin(0, 1'b0);
      chk_ev(EV_CHANGE, 0, PT_OFF, 1'b0, 1'b0, "single off");
      rd(STATE_LO_OFF, 32'h0000_0002, 1'b0, "state reg");
      wr(TIME_OFF, 32'h0000_1000);
      rd(TIME_OFF, 32'h0000_1001, 1'b0, "local time");
      $display("test single done");
   endtask

   task automatic t_double();
      logic [1:0]   seq [4];
      point_state_t ex [4];
      seq = '{2'b10, 2'b11, 2'b01, 2'b00};
      ex = '{PT_ON, PT_INVALID, PT_OFF, PT_TRANS};
      wr(DP_OFF, 32'h0000_0002);
      wr(TAG_LO_OFF, 32'h0000_0004);
      cfg(2, 16'h0004, 8'h03, 8'h01);
      cfg(3, 16'h0004, 8'h03, 8'h01);
      slow <= 1'b1;
      repeat (20) @(posedge pclk);
      fm.got.delete();
      for (int k = 0; k < 4; k++)
      begin
         @(posedge pclk);
         fm.pins[3:2] <= seq[k];
         chk_ev(EV_CHANGE, 2, ex[k], 1'b0, 1'b1, "double");
      end
      repeat (40) @(posedge pclk);
      chk(32'(fm.got.size()), 32'h0, "high half silent");
      slow <= 1'b0;
      $display("test double done");
   endtask

   task automatic t_chatter();
      event_t e;
      int     blk;
      int     unb;
      int     bad;
      cfg(4, 16'h0004, 8'h03, 8'h01);
      fm.got.delete();
      for (int k = 0; k < 10; k++)
      begin
         pin(4, logic'(k % 2 == 0));
         repeat (11) @(posedge pclk);
      end
      repeat (20) @(posedge pclk);
      chk(32'(qual[4]), 32'h1, "blocked flag");
      // a quiet window must pass first, so allow three windows
      repeat (3 * WIN)
         if (qual[4] !== 1'b0)
            @(posedge pclk);
      chk(32'(qual[4]), 32'h0, "released");
      repeat (20) @(posedge pclk);
      blk = -1;
      unb = -1;
      bad = 0;
      foreach (fm.got[j])
      begin
         e = fm.got[j];
         if (e.kind == EV_BLOCK && e.index == 6'd4 && e.invalid === 1'b1)
            blk = j;
         if (e.kind == EV_UNBLOCK && e.index == 6'd4)
            unb = j;
         if (e.kind == EV_CHANGE && blk >= 0 && unb < 0)
            bad++;
      end
      chk(32'(blk >= 0), 32'h1, "block event");
      chk(32'(unb > blk), 32'h1, "unblock event");
      chk(32'(bad), 32'h0, "frozen while blocked");
      $display("test chatter done");
   endtask

   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_single();
      t_double();
      t_chatter();
      close_out();
   end
endmodule
